/* File: pss_defines.svh */
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
// Timebase
`define PSS_CLK_MHZ 250
`define PSS_US_CYC (`PSS_CLK_MHZ * 1)
`define PSS_US_PER_MS 1000
// Slot delays, in units of 32 us
`define PSS_SLOT_UNIT_US 32
`define PSS_SLOT_DEF_US 128
`define PSS_SLOT_MIN_US 32
`define PSS_SLOT_MAX_US 8000
`define PSS_SLOT_DEF (`PSS_SLOT_DEF_US / `PSS_SLOT_UNIT_US)
`define PSS_SLOT_MIN (`PSS_SLOT_MIN_US / `PSS_SLOT_UNIT_US)
`define PSS_SLOT_MAX (`PSS_SLOT_MAX_US / `PSS_SLOT_UNIT_US)
// Wait step and alive window, in ms; reset release delay, in us
`define PSS_WAIT_TO_MS 500
`define PSS_WD_MIN_MS 110
`define PSS_WD_MAX_MS 2048
`define PSS_RST_US 16
// Register byte offsets
`define PSS_OFF_CTRL 8'h00
`define PSS_OFF_TIMER 8'h04
`define PSS_OFF_PTR 8'h08
`define PSS_OFF_STAY 8'h0C
`define PSS_OFF_GPI 8'h10
`define PSS_OFF_PDCFG 8'h14
`define PSS_OFF_WDOG 8'h18
`define PSS_OFF_STAT 8'h1C
`define PSS_OFF_MAP 8'h20
`define PSS_OFF_SUP 8'h24
// Control fields
`define PSS_C_SYS 0
`define PSS_C_PWR 1
`define PSS_C_THIRD 2
`define PSS_C_STBY 3
`define PSS_C_SHUT 4
`define PSS_C_DEF 5
`define PSS_C_RSTOPT 6
`define PSS_C_DEFER 7
`define PSS_C_TOEN 8
`define PSS_C_WMODE 9
`define PSS_C_OTP 10
`define PSS_C_FB2 11
`define PSS_C_WDPD 12
`define PSS_C_SCALE 16
// Status fields
`define PSS_S_WEVT 0
`define PSS_S_WTO 1
`define PSS_S_WDF 2
`define PSS_S_IRQ 3
// Slot map: bit 14 wait step, bit 15 powerdown-disable step
`define PSS_M_WAIT 14
`define PSS_M_PDDIS 15
// Reset values
`define PSS_CTRL_RST 19'h10027
`define PSS_PTR_RST 16'h1642
`endif

/* File: pss_host_model.sv */
`timescale 1ns/10ps
module pss_host_model #(
   parameter int GAP = 1000
) (
   input wire logic sys_clk_i,
   input wire logic serve_i,
   output logic keepalive_o
);
   int cnt_reg = 0;
   initial keepalive_o = 1'b0;
   // Gap sits past the fixed lower bound, since earlier triggers are dropped
   always @(posedge sys_clk_i) begin
      cnt_reg <= (serve_i && cnt_reg < GAP) ? cnt_reg + 1 : 0;
      keepalive_o <= serve_i && (cnt_reg == GAP);
   end
endmodule

/* File: pss_pkg.sv */
package pss_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_READ = 5'b00010,
      ST_APPLY = 5'b00100,
      ST_WAITIN = 5'b01000,
      ST_DELAY = 5'b10000
   } pss_state_e;
   typedef logic [3:0] pss_slot_t;
   typedef logic [15:0] pss_mask_t;
endpackage

/* File: pss_slot_mem.sv */
`timescale 1ns/10ps
module pss_slot_mem #(
   parameter int AW = 4,
   parameter int DW = 16
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [2**AW];
   // Cleared at reset so every slot starts as a dummy slot
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < 2**AW; i++) begin
            mem[i] <= '0;
         end
      end else if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   // Registered read: one cycle of latency
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

/* File: pss_tick_if.sv */
`timescale 1ns/10ps
interface pss_tick_if;
   logic us_tick;
   logic ms_tick;
   modport src (output us_tick, output ms_tick);
   modport snk (input us_tick, input ms_tick);
endinterface

/* File: pss_timebase.sv */
`timescale 1ns/10ps
module pss_timebase #(
   parameter int US_CYC = 250,
   parameter int US_PER_MS = 1000
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   pss_tick_if.src tk
);
   logic [15:0] cyc_reg;
   logic [15:0] us_reg;
   // One shared timebase; every delay counts these enables
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cyc_reg <= 16'h0000;
         tk.us_tick <= 1'b0;
      end else if (cyc_reg == 16'(US_CYC - 1)) begin
         cyc_reg <= 16'h0000;
         tk.us_tick <= 1'b1;
      end else begin
         cyc_reg <= cyc_reg + 16'h0001;
         tk.us_tick <= 1'b0;
      end
   end
   // Millisecond enable from the microsecond enable
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         us_reg <= 16'h0000;
         tk.ms_tick <= 1'b0;
      end else begin
         tk.ms_tick <= 1'b0;
         if (tk.us_tick) begin
            if (us_reg == 16'(US_PER_MS - 1)) begin
               us_reg <= 16'h0000;
               tk.ms_tick <= 1'b1;
            end else begin
               us_reg <= us_reg + 16'h0001;
            end
         end
      end
   end
endmodule

/* File: pss_top.sv */
// Summary of operation
// R1: Programmable delay between slots, 32us to 8ms
// R2: Empty slot waits dummy delay, does nothing
// R3: Reload both delays from OTP at startup
// R4: Power-down reverses order; ready high, done event
// R5: Stay-on supplies stay enabled, switch to B
// R6: Pin-controlled regulators left untouched
// R7: Third enable cleared: third domain only
// R8: Second enable cleared: third then second
// R9: System enable cleared: down to slot 0
// R10: Standby stops at partial-down pointer
// R11: Wake events accepted only in powerdown or reset mode
// R12: Deferral holds interrupt until active mode
// R13: Shutdown goes to slot 0, then reset
// R14: Feature-disable applied down, released up
// R15: Reset output asserted before power-down
// R16: Wait step holds until input event
// R17: Wait timeout 500ms: fault, go to reset
// R18: Wait step as timer; skipped on shutdown
// R19: Missed alive write: fault, go to reset
// R20: Window 110ms min, 2.048s times 2^(scale-1)
// R21: Valid write restarts; monitor stops powering down
// R22: Keep-alive pin may trigger the watchdog
// R23: Watchdog armed at second-domain end
// R24: One slot per delay; one timebase
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "pss_defines.svh"
module pss_top #(
   parameter int US_CYC = `PSS_US_CYC,
   parameter int US_PER_MS = `PSS_US_PER_MS,
   parameter int WD_MAX_MS = `PSS_WD_MAX_MS,
   parameter int NSUP = 14
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic [7:0] otp_slot_delay_i,
   input wire logic [7:0] otp_dummy_delay_i,
   input wire logic wait_sync_input_i,
   input wire logic hw_keepalive_pin_i,
   input wire logic wake_event_i,
   input wire logic irq_event_i,
   input wire logic reset_event_i,
   output logic [NSUP-1:0] supply_en_o,
   output logic [NSUP-1:0] volt_alt_sel_o,
   output logic [7:0] pd_feature_dis_o,
   output logic ready_o,
   output logic sequence_done_event_o,
   output logic powerdown_mode_o,
   output logic reset_mode_o,
   output logic interrupt_out_n_o,
   output logic system_reset_out_n_o
);
   import pss_pkg::*;

   localparam int WAIT_TO = `PSS_WAIT_TO_MS;
   localparam int WD_MIN = `PSS_WD_MIN_MS;

   // Slot delay in us, clamped to the legal 32 us .. 8 ms range
   function automatic logic [17:0] delay_us(input logic [7:0] v);
      logic [7:0] c;
      c = v;
      if (c < 8'(`PSS_SLOT_MIN)) c = 8'(`PSS_SLOT_MIN);
      if (c > 8'(`PSS_SLOT_MAX)) c = 8'(`PSS_SLOT_MAX);
      return 18'(c) * 18'(`PSS_SLOT_UNIT_US);
   endfunction

   // Write strobe decode for the data phase
   function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                   input logic [7:0] off);
      return wr && (a == off);
   endfunction

   pss_tick_if tk();
   pss_timebase #(.US_CYC(US_CYC), .US_PER_MS(US_PER_MS)) u_tb (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .tk(tk.src)
   );

   logic dp_wr_reg;
   logic [7:0] dp_addr_reg;
   logic [31:0] rdata_reg;
   logic [18:0] ctrl_reg;
   logic [15:0] timer_reg;
   logic [15:0] ptr_reg;
   logic [NSUP-1:0] stay_reg;
   logic [NSUP-1:0] gpi_reg;
   logic [15:0] pdcfg_reg;
   logic [3:0] stat_reg;
   pss_state_e st_reg;
   pss_slot_t pos_reg;
   pss_slot_t cur_reg;
   pss_slot_t tgt;
   pss_mask_t mask;
   logic up_reg;
   logic [17:0] dly_reg;
   logic [9:0] wt_ms_reg;
   logic forced_reg;
   logic pd_mode_reg;
   logic rst_mode_reg;
   logic ready_reg;
   logic done_reg;
   logic nres_reg;
   logic [7:0] rst_cnt_reg;
   logic rst_run_reg;
   logic irq_n_reg;
   logic wsi_d_reg;
   logic kp_d_reg;
   logic wd_on_reg;
   logic wd_first_reg;
   logic [17:0] wd_ms_reg;
   logic [17:0] wd_max;
   logic ap_valid;
   logic to_reset;
   logic wake_ok;
   logic active;
   logic wd_trig;
   logic wd_fault;
   logic wt_fault;
   logic dly_done;
   logic start_down;
   logic [2:0] scale;

   assign ap_valid = hsel_i & htrans_i[1] & hready_i;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = rdata_reg;
   assign scale = ctrl_reg[`PSS_C_SCALE+:3];

   // Address phase capture; only byte offsets below 0x100 are mapped
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else begin
         dp_wr_reg <= ap_valid & hwrite_i & (haddr_i[31:8] == 24'h000000);
         dp_addr_reg <= haddr_i[7:0];
      end
   end

   // Read data registered at the address phase; unmapped reads give zero
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         rdata_reg <= 32'h00000000;
      end else if (ap_valid && !hwrite_i) begin
         rdata_reg <= 32'h00000000;
         if (haddr_i[31:8] == 24'h000000) begin
            unique case (haddr_i[7:0])
               `PSS_OFF_CTRL: rdata_reg <= 32'(ctrl_reg);
               `PSS_OFF_TIMER: rdata_reg <= 32'(timer_reg);
               `PSS_OFF_PTR: rdata_reg <= 32'(ptr_reg);
               `PSS_OFF_STAY: rdata_reg <= 32'(stay_reg);
               `PSS_OFF_GPI: rdata_reg <= 32'(gpi_reg);
               `PSS_OFF_PDCFG: rdata_reg <= 32'(pdcfg_reg);
               `PSS_OFF_STAT: rdata_reg <= {17'h00000, ready_reg, rst_mode_reg,
                                            pd_mode_reg, pos_reg, 4'h0, stat_reg};
               `PSS_OFF_SUP: rdata_reg <= {2'h0, volt_alt_sel_o, 2'h0, supply_en_o};
               default: rdata_reg <= 32'h00000000; // Watchdog bit reads zero R21
            endcase
         end
      end
   end

   // Wake accepted only once powerdown or reset mode is reached
   assign wake_ok = wake_event_i & (pd_mode_reg | rst_mode_reg); // R11

   // Control register; a wake sets the system enable over a software write
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ctrl_reg <= `PSS_CTRL_RST;
      end else begin
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_CTRL)) ctrl_reg <= hwdata_i[18:0];
         if (wake_ok) begin
            ctrl_reg[`PSS_C_SYS] <= 1'b1;
            ctrl_reg[`PSS_C_SHUT] <= 1'b0;
         end
      end
   end

   // Configuration registers; delays reload from OTP at system power-up
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         timer_reg <= {8'(`PSS_SLOT_DEF), 8'(`PSS_SLOT_DEF)};
         ptr_reg <= `PSS_PTR_RST;
         stay_reg <= '0;
         gpi_reg <= '0;
         pdcfg_reg <= 16'h0000;
      end else begin
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_TIMER)) timer_reg <= hwdata_i[15:0];
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_PTR)) ptr_reg <= hwdata_i[15:0];
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_STAY)) stay_reg <= hwdata_i[NSUP-1:0];
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_GPI)) gpi_reg <= hwdata_i[NSUP-1:0];
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_PDCFG)) pdcfg_reg <= hwdata_i[15:0];
         if (st_reg == ST_IDLE && pos_reg == 4'h0 && tgt != 4'h0 && ctrl_reg[`PSS_C_OTP])
            timer_reg <= {otp_dummy_delay_i, otp_slot_delay_i}; // R3
      end
   end

   pss_slot_mem #(.AW(4), .DW(16)) u_map (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .we_i(wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_MAP)),
      .waddr_i(hwdata_i[19:16]),
      .wdata_i(hwdata_i[15:0]),
      .raddr_i(cur_reg),
      .rdata_o(mask)
   );

   // Target slot from the domain enables; shutdown and faults win
   assign to_reset = forced_reg | ctrl_reg[`PSS_C_SHUT]; // R13
   always_comb begin
      if (to_reset) tgt = 4'h0; // R13
      else if (!ctrl_reg[`PSS_C_SYS]) tgt = ctrl_reg[`PSS_C_STBY] ? ptr_reg[15:12] : 4'h0; // R9 R10
      else if (!ctrl_reg[`PSS_C_PWR]) tgt = ptr_reg[3:0]; // R8
      else if (!ctrl_reg[`PSS_C_THIRD]) tgt = ptr_reg[7:4]; // R7
      else tgt = ptr_reg[11:8];
   end

   assign dly_done = tk.us_tick && dly_reg <= 18'h00001; // R24
   assign start_down = st_reg == ST_IDLE && tgt < pos_reg;
   assign wt_fault = st_reg == ST_WAITIN && ctrl_reg[`PSS_C_TOEN]
                     && wt_ms_reg >= 10'(WAIT_TO); // R17

   // Sequencer: one slot per delay interval, up or down
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         st_reg <= ST_IDLE;
         pos_reg <= 4'h0;
         cur_reg <= 4'h0;
         up_reg <= 1'b1;
         dly_reg <= 18'h00000;
      end else begin
         unique case (st_reg)
            ST_IDLE: if (pos_reg != tgt) begin
               up_reg <= tgt > pos_reg;
               cur_reg <= (tgt > pos_reg) ? pos_reg + 4'h1 : pos_reg; // R4
               st_reg <= ST_READ;
            end
            ST_READ: st_reg <= ST_APPLY;
            ST_APPLY: begin
               if (mask[`PSS_M_WAIT] && !to_reset) begin // R18
                  if (ctrl_reg[`PSS_C_WMODE]) begin
                     dly_reg <= 18'(pdcfg_reg[15:8]) * 18'(US_PER_MS); // R18
                     st_reg <= ST_DELAY;
                  end else begin
                     st_reg <= ST_WAITIN; // R16
                  end
               end else begin
                  dly_reg <= (mask == 16'h0000) ? delay_us(timer_reg[15:8]) // R2
                                                : delay_us(timer_reg[7:0]); // R1
                  st_reg <= ST_DELAY;
               end
            end
            ST_WAITIN: if (stat_reg[`PSS_S_WEVT] || wt_fault || to_reset) begin // R16 R17
               dly_reg <= delay_us(timer_reg[7:0]);
               st_reg <= ST_DELAY;
            end
            ST_DELAY: if (dly_done) begin
               if (up_reg) begin
                  pos_reg <= cur_reg;
                  st_reg <= ST_IDLE;
               end else begin
                  pos_reg <= (cur_reg == 4'h0) ? 4'h0 : cur_reg - 4'h1;
                  if (cur_reg == 4'h1 && tgt == 4'h0 && ctrl_reg[`PSS_C_DEF]) begin
                     cur_reg <= 4'h0; // R9
                     st_reg <= ST_READ;
                  end else begin
                     st_reg <= ST_IDLE;
                  end
               end
            end else if (tk.us_tick) begin
               dly_reg <= dly_reg - 18'h00001;
            end
         endcase
      end
   end

   // Supply actions when a slot is applied; pin-controlled ones are skipped
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         supply_en_o <= '0;
         volt_alt_sel_o <= '0;
         pd_feature_dis_o <= 8'h00;
      end else if (st_reg == ST_APPLY) begin
         for (int i = 0; i < NSUP; i++) begin
            if (mask[i] && !gpi_reg[i]) begin // R6
               if (up_reg) begin
                  supply_en_o[i] <= 1'b1;
                  volt_alt_sel_o[i] <= 1'b0;
               end else if (stay_reg[i]) begin
                  volt_alt_sel_o[i] <= 1'b1; // R5
               end else begin
                  supply_en_o[i] <= 1'b0; // R4
               end
            end
         end
         if (mask[`PSS_M_PDDIS])
            pd_feature_dis_o <= up_reg ? 8'h00 : pdcfg_reg[7:0]; // R14
      end
   end

   // Wait step timeout counter in ms
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || st_reg != ST_WAITIN) begin
         wt_ms_reg <= 10'h000;
      end else if (tk.ms_tick && wt_ms_reg != 10'h3FF) begin
         wt_ms_reg <= wt_ms_reg + 10'h001;
      end
   end

   // Ready, done pulse and mode flags
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ready_reg <= 1'b0;
         done_reg <= 1'b0;
         pd_mode_reg <= 1'b0;
         rst_mode_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (st_reg != ST_IDLE || pos_reg != tgt) begin
            ready_reg <= 1'b1; // R4
            pd_mode_reg <= 1'b0;
            rst_mode_reg <= 1'b0;
         end else if (ready_reg) begin
            ready_reg <= 1'b0;
            done_reg <= 1'b1; // R4
            rst_mode_reg <= to_reset; // R13
            pd_mode_reg <= !to_reset && !ctrl_reg[`PSS_C_SYS]; // R10
         end
      end
   end

   // Active mode: idle at or above the second-domain end
   assign active = st_reg == ST_IDLE && ctrl_reg[`PSS_C_PWR] && pos_reg >= ptr_reg[7:4];

   // Alive window scaled x1..x64; zero disables the monitor
   assign wd_max = 18'(WD_MAX_MS) << (scale - 3'h1); // R20
   assign wd_trig = (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_WDOG) && hwdata_i[0])
                    || (ctrl_reg[`PSS_C_FB2] && hw_keepalive_pin_i && !kp_d_reg); // R22
   assign wd_fault = wd_on_reg && scale != 3'h0 && wd_ms_reg >= wd_max; // R19

   // Watchdog monitor
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         wd_on_reg <= 1'b0;
         wd_first_reg <= 1'b0;
         wd_ms_reg <= 18'h00000;
         kp_d_reg <= 1'b0;
      end else begin
         kp_d_reg <= hw_keepalive_pin_i;
         if (st_reg == ST_DELAY && dly_done && up_reg && cur_reg == ptr_reg[7:4]) begin
            wd_on_reg <= 1'b1; // R23
            wd_first_reg <= 1'b1;
            wd_ms_reg <= 18'h00000;
         end else if (wd_fault || (start_down && !ctrl_reg[`PSS_C_WDPD])) begin
            wd_on_reg <= 1'b0; // R21
         end else if (wd_trig && (wd_first_reg || wd_ms_reg >= 18'(WD_MIN))) begin
            wd_ms_reg <= 18'h00000; // R21
            wd_first_reg <= 1'b0;
         end else if (tk.ms_tick && wd_on_reg && scale != 3'h0) begin
            wd_ms_reg <= wd_ms_reg + 18'h00001;
         end
      end
   end

   // Sticky status; hardware set wins over a write-one clear
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         stat_reg <= 4'h0;
         wsi_d_reg <= 1'b0;
         forced_reg <= 1'b0;
      end else begin
         wsi_d_reg <= wait_sync_input_i;
         if (wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_STAT)) stat_reg <= stat_reg & ~hwdata_i[3:0];
         if (wake_ok) forced_reg <= 1'b0;
         if (wait_sync_input_i && !wsi_d_reg) stat_reg[`PSS_S_WEVT] <= 1'b1; // R16
         if (irq_event_i) stat_reg[`PSS_S_IRQ] <= 1'b1;
         if (wt_fault) begin
            stat_reg[`PSS_S_WTO] <= 1'b1; // R17
            forced_reg <= 1'b1;
         end
         if (wd_fault) begin
            stat_reg[`PSS_S_WDF] <= 1'b1; // R19
            forced_reg <= 1'b1;
         end
      end
   end

   // Interrupt output, held back outside active mode when deferral is set
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) irq_n_reg <= 1'b1;
      else irq_n_reg <= !(stat_reg[`PSS_S_IRQ] && !(ctrl_reg[`PSS_C_DEFER] && !active)); // R12
   end

   // Reset output: low before power-down, timed release after a reset event on the next power-up
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         nres_reg <= 1'b1;
         rst_run_reg <= 1'b0;
         rst_cnt_reg <= 8'h00;
      end else if (start_down && ctrl_reg[`PSS_C_RSTOPT]) begin
         nres_reg <= 1'b0; // R15
         rst_run_reg <= 1'b0;
      end else if (!nres_reg && !rst_run_reg && up_reg && reset_event_i) begin
         rst_run_reg <= 1'b1; // R15
         rst_cnt_reg <= 8'(`PSS_RST_US);
      end else if (rst_run_reg && tk.us_tick) begin
         if (rst_cnt_reg <= 8'h01) begin
            nres_reg <= 1'b1;
            rst_run_reg <= 1'b0;
         end else begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
         end
      end
   end

   assign ready_o = ready_reg;
   assign sequence_done_event_o = done_reg;
   assign powerdown_mode_o = pd_mode_reg;
   assign reset_mode_o = rst_mode_reg;
   assign interrupt_out_n_o = irq_n_reg;
   assign system_reset_out_n_o = nres_reg;

   property p_stay_on;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (st_reg == ST_APPLY && !up_reg && mask[0] && !gpi_reg[0] && stay_reg[0])
      |=> volt_alt_sel_o[0] && supply_en_o[0] == $past(supply_en_o[0]);
   endproperty
   a_stay_on: assert property (p_stay_on) else $error("stay-on supply changed"); // R5
   property p_gpi;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (st_reg == ST_APPLY && gpi_reg[1]) |=> $stable(supply_en_o[1]);
   endproperty
   a_gpi: assert property (p_gpi) else $error("pin-controlled supply changed"); // R6
   property p_done;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      done_reg |-> !ready_reg && pos_reg == tgt && $past(ready_reg);
   endproperty
   a_done: assert property (p_done) else $error("done without reaching target"); // R4
   property p_wake;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (wake_event_i && !pd_mode_reg && !rst_mode_reg && !ctrl_reg[`PSS_C_SYS]
       && !wr_hit(dp_wr_reg, dp_addr_reg, `PSS_OFF_CTRL)) |=> !ctrl_reg[`PSS_C_SYS];
   endproperty
   a_wake: assert property (p_wake) else $error("wake taken outside powerdown"); // R11
   property p_wto;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      wt_fault |=> stat_reg[`PSS_S_WTO] && forced_reg && tgt == 4'h0;
   endproperty
   a_wto: assert property (p_wto) else $error("wait timeout not handled"); // R17
   sequence s_fault;
      wd_fault ##1 stat_reg[`PSS_S_WDF];
   endsequence
   property p_wd;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_fault |-> forced_reg && !wd_on_reg;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog fault not handled"); // R19
   property p_step;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      $changed(pos_reg) |-> $past(st_reg) == ST_DELAY && $past(dly_done);
   endproperty
   a_step: assert property (p_step) else $error("slot moved without delay"); // R24
   property p_shut;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (st_reg == ST_APPLY && mask[`PSS_M_WAIT] && to_reset) |=> st_reg == ST_DELAY;
   endproperty
   a_shut: assert property (p_shut) else $error("wait not skipped on shutdown"); // R18
endmodule

/* File: tb_power_sequencer_shutdown_watchdog.sv */
`timescale 1ns/10ps
module tb_power_sequencer_shutdown_watchdog;
   logic clk = 1'b0, nrst = 1'b0, hwrite = 1'b0, hrdy, serve = 1'b0, kal, wake = 1'b0;
   logic wsi = 1'b0, irq = 1'b0, hresp, irqn, srn;
   logic [7:0] pdd;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [13:0] sen, alt;
   logic done, rdy, pdm, rstm;
   int errors = 0, checks = 0, n;
   always #2 clk = ~clk;
   pss_top #(.US_CYC(2), .US_PER_MS(4), .WD_MAX_MS(16)) dut (.sys_clk_i(clk), .nrst_i(nrst),
      .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
      .otp_slot_delay_i(8'h04), .otp_dummy_delay_i(8'h02), .wait_sync_input_i(wsi),
      .hw_keepalive_pin_i(kal), .wake_event_i(wake), .irq_event_i(irq),
      .reset_event_i(1'b0), .supply_en_o(sen), .volt_alt_sel_o(alt), .pd_feature_dis_o(pdd),
      .ready_o(rdy), .sequence_done_event_o(done), .powerdown_mode_o(pdm),
      .reset_mode_o(rstm), .interrupt_out_n_o(irqn), .system_reset_out_n_o(srn));
   pss_host_model #(.GAP(1000)) host (.sys_clk_i(clk), .serve_i(serve), .keepalive_o(kal));
   task print_verdict;
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Single word transfer; the slave ties hreadyout high and is always ready, though hready is still polled
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   // Done is a one-cycle pulse, so it is sampled on the falling edge
   task wait_done;
      n = 0;
      @(negedge clk);
      while (done !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      chk("done", 32'h1, {31'h0, done});
   endtask
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      bus(1'b0, 32'h00, 32'h0); chk("ctrl reset", 32'h00010027, rd);
      bus(1'b0, 32'h30, 32'h0); chk("unmapped", 32'h0, rd);
      bus(1'b1, 32'h00, 32'h00000020); wait_done();
      chk("resp", 32'h0, {31'h0, hresp});
      bus(1'b1, 32'h20, 32'h00010001);
      bus(1'b1, 32'h20, 32'h00028006);
      bus(1'b1, 32'h20, 32'h00034000);
      bus(1'b1, 32'h0C, 32'h00000001);
      bus(1'b1, 32'h14, 32'h000000A5);
      bus(1'b1, 32'h1C, 32'h00000001);
      bus(1'b1, 32'h00, 32'h00000027);
      repeat (2) @(posedge clk);
      chk("ready", 32'h1, {31'h0, rdy});
      // The wait step at slot 3 holds the power-up at position 2
      repeat (1500) @(posedge clk);
      bus(1'b0, 32'h1C, 32'h0);
      chk("wait hold", 32'h2, (rd >> 8) & 32'hF);
      wsi <= 1'b1;
      wait_done(); chk("up", 32'h7, {18'h0, sen});
      bus(1'b1, 32'h10, 32'h00000002);
      bus(1'b1, 32'h00, 32'h00000026); wait_done();
      chk("down en", 32'h3, {18'h0, sen});
      chk("down alt", 32'h1, {18'h0, alt});
      chk("pd mode", 32'h1, {31'h0, pdm});
      chk("pd features", 32'hA5, {24'h0, pdd});
      // Event raised in powerdown with deferral set
      bus(1'b1, 32'h00, 32'h000000A6);
      irq <= 1'b1;
      @(posedge clk) irq <= 1'b0;
      repeat (4) @(posedge clk);
      chk("deferred", 32'h1, {31'h0, irqn});
      // Keep-alive pin serviced by the host, wide window, reset option on
      serve <= 1'b1;
      bus(1'b1, 32'h00, 32'h000508E7); wait_done();
      chk("irq in active", 32'h0, {31'h0, irqn});
      bus(1'b1, 32'h18, 32'h1);
      bus(1'b0, 32'h18, 32'h0);
      chk("alive reads", 32'h0, rd);
      repeat (6000) @(posedge clk);
      chk("served", 32'h0, {31'h0, rstm});
      chk("reset out held", 32'h1, {31'h0, srn});
      serve <= 1'b0;
      n = 0;
      while (rstm !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      chk("alive lost", 32'h1, {31'h0, rstm});
      chk("reset out", 32'h0, {31'h0, srn});
      bus(1'b0, 32'h1C, 32'h0); chk("fault bit", 32'h4, rd & 32'h4);
      // Warm boot by wake: no wait event, so the timeout forces reset mode
      bus(1'b1, 32'h1C, 32'h00000001);
      bus(1'b1, 32'h00, 32'h00050DE7);
      wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      wait_done();
      chk("timeout reset", 32'h1, {31'h0, rstm});
      bus(1'b0, 32'h1C, 32'h0); chk("timeout bit", 32'h2, rd & 32'h2);
      bus(1'b0, 32'h04, 32'h0); chk("otp reload", 32'h0204, rd);
      print_verdict();
   end
endmodule
